/* src/imu_dvel_gyro_bias_regs.sv */
// Velocity-change outputs (Y, Z) and user rate-offset
// registers (X, Y) of an inertial unit.
// Assumes the serial front end and sensor path run on ref_clk.
//
// Functional notes
// - Y velocity high word is 16-bit two's complement, zero is 0, +-400 m/s.
// - Z velocity high word uses the same format and range.
// - Each axis has a low word holding extra resolution bits.
// - Joined 32-bit value saturates at 0x7fffffff and 0x80000000.
// - One 16-bit step is 400/2^15 m/s; 0x7fff top, 0x8000 is -400.
// - Factory coefficients stay hidden; only user offsets are visible.
// - Each rate sensor has its own writable offset registers.
// - The correction chain runs at 2000 Hz from the internal clock.
// - X offset low word is read/write, resets to zero, flash backed.
// - X offset high word is read/write and resets to zero.
// - X offset words join into one 32-bit shift of the X rate.
// - Y offset words join into one 32-bit shift of the Y rate.
// - Velocity change is a trapezoid sum over the decimation count.
`timescale 1ns/1ns
`default_nettype none

module imu_dvel_gyro_bias_regs #(
  parameter int TICK_CYC = imu_pkg::TICK_CYC,
  parameter int DEC_W    = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire imu_pkg::reg_req_t reg_req,
  output logic [15:0]            reg_rdata,
  output logic                   reg_rvalid,
  input  wire imu_pkg::accel_t   accel,
  input  wire logic [DEC_W-1:0]  decimation_setting,
  input  wire logic [31:0]       rate_x_raw,
  input  wire logic [31:0]       rate_y_raw,
  output logic [31:0]            rate_x_out,
  output logic [31:0]            rate_y_out,
  output logic                   rate_valid,
  output logic                   dv_ready,
  output logic [31:0]            flash_x_offset,
  output logic [31:0]            flash_y_offset
);

  ////////////////////////////////////////////////////////////
  // Declarations

  localparam int ACC_W     = 40;
  localparam int HI_LSB_M1 = imu_pkg::HI_LSB - 1;

  logic [15:0]      xb_lo_r;
  logic [15:0]      xb_hi_r;
  logic [15:0]      yb_lo_r;
  logic [15:0]      yb_hi_r;
  logic [15:0]      div_r;
  logic             tick;
  logic [15:0]      ay_prev_r;
  logic [15:0]      az_prev_r;
  logic [ACC_W-1:0] acc_y_r;
  logic [ACC_W-1:0] acc_z_r;
  logic [ACC_W-1:0] acc_y_nxt;
  logic [ACC_W-1:0] acc_z_nxt;
  logic [DEC_W-1:0] dec_cnt_r;
  logic             dec_done;
  logic [31:0]      dv_y_r;
  logic [31:0]      dv_z_r;
  logic [15:0]      rd_nxt;

  ////////////////////////////////////////////////////////////
  // Helpers

  // Word match; the odd byte of a pair hits the same word
  function automatic logic hit(input logic [6:0] a,
                               input logic [6:0] o);
    hit = (a[6:1] == o[6:1]);
  endfunction

  // Sign-extended sum of a sample and its predecessor
  function automatic logic [ACC_W-1:0] pair_sum(
    input logic [15:0] cur,
    input logic [15:0] prev);
    logic [ACC_W-1:0] c;
    logic [ACC_W-1:0] p;
    c = {{(ACC_W-16){cur[15]}}, cur};
    p = {{(ACC_W-16){prev[15]}}, prev};
    pair_sum = c + p;
  endfunction

  // Scale the sum and clamp into the 32-bit code range
  function automatic logic [31:0] scale_sat(
    input logic [ACC_W-1:0] s);
    logic [ACC_W+imu_pkg::DV_SHIFT-1:0] w;
    logic [ACC_W+imu_pkg::DV_SHIFT-1:0] hi;
    logic [ACC_W+imu_pkg::DV_SHIFT-1:0] lo;
    w  = {s, {imu_pkg::DV_SHIFT{1'b0}}};
    hi = {{(ACC_W+imu_pkg::DV_SHIFT-32){1'b0}},
          imu_pkg::DV_POS_MAX};
    lo = {{(ACC_W+imu_pkg::DV_SHIFT-32){1'b1}},
          imu_pkg::DV_NEG_MAX};
    if (!w[ACC_W+imu_pkg::DV_SHIFT-1] && (w > hi)) begin
      scale_sat = imu_pkg::DV_POS_MAX;
    end else if (w[ACC_W+imu_pkg::DV_SHIFT-1] && (w < lo)) begin
      scale_sat = imu_pkg::DV_NEG_MAX;
    end else begin
      scale_sat = w[31:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // Sample clock

  // Internal 2000 Hz sample strobe from ref_clk
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 16'h0000;
    end else if (div_r == 16'(TICK_CYC - 1)) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  assign tick = (div_r == 16'(TICK_CYC - 1));

  ////////////////////////////////////////////////////////////
  // Rate offset registers

  // Host writes land in the matching word; velocity words and
  // unmapped offsets ignore writes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      xb_lo_r <= imu_pkg::BIAS_RST;
      xb_hi_r <= imu_pkg::BIAS_RST;
      yb_lo_r <= imu_pkg::BIAS_RST;
      yb_hi_r <= imu_pkg::BIAS_RST;
    end else if (reg_req.wr) begin
      if (hit(reg_req.addr, imu_pkg::OFS_XB_LO)) begin
        xb_lo_r <= reg_req.wdata;
      end
      if (hit(reg_req.addr, imu_pkg::OFS_XB_HI)) begin
        xb_hi_r <= reg_req.wdata;
      end
      if (hit(reg_req.addr, imu_pkg::OFS_YB_LO)) begin
        yb_lo_r <= reg_req.wdata;
      end
      if (hit(reg_req.addr, imu_pkg::OFS_YB_HI)) begin
        yb_hi_r <= reg_req.wdata;
      end
    end
  end

  // Flash image holds only the user offsets, never velocity
  assign flash_x_offset = {xb_hi_r, xb_lo_r};
  assign flash_y_offset = {yb_hi_r, yb_lo_r};

  ////////////////////////////////////////////////////////////
  // Rate correction

  // Offset added once per sample; high word shares the rate
  // output's scale so the host can copy a reading straight in
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_x_out <= 32'h00000000;
      rate_y_out <= 32'h00000000;
      rate_valid <= 1'b0;
    end else begin
      rate_valid <= tick;
      if (tick) begin
        rate_x_out <= rate_x_raw + {xb_hi_r, xb_lo_r};
        rate_y_out <= rate_y_raw + {yb_hi_r, yb_lo_r};
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Velocity change integration

  // Previous samples for the trapezoid
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ay_prev_r <= 16'h0000;
      az_prev_r <= 16'h0000;
    end else if (tick) begin
      ay_prev_r <= accel.y;
      az_prev_r <= accel.z;
    end
  end

  // Decimation count; a setting of N sums N+1 samples
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_cnt_r <= '0;
    end else if (tick) begin
      if (dec_done) begin
        dec_cnt_r <= '0;
      end else begin
        dec_cnt_r <= dec_cnt_r + DEC_W'(1);
      end
    end
  end

  // A lowered setting mid-window closes it at once
  assign dec_done = tick && (dec_cnt_r >= decimation_setting);

  // Running sums; restart from zero after each result
  always_comb begin
    acc_y_nxt = acc_y_r + pair_sum(accel.y, ay_prev_r);
    acc_z_nxt = acc_z_r + pair_sum(accel.z, az_prev_r);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_y_r <= '0;
      acc_z_r <= '0;
    end else if (dec_done) begin
      acc_y_r <= '0;
      acc_z_r <= '0;
    end else if (tick) begin
      acc_y_r <= acc_y_nxt;
      acc_z_r <= acc_z_nxt;
    end
  end

  // Both words of a result latch together in one cycle; reads
  // take no snapshot, so a high word read before a result can
  // sit beside a low word read after it from the next window
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dv_y_r   <= imu_pkg::DV_RST;
      dv_z_r   <= imu_pkg::DV_RST;
      dv_ready <= 1'b0;
    end else begin
      dv_ready <= dec_done;
      if (dec_done) begin
        dv_y_r <= scale_sat(acc_y_nxt);
        dv_z_r <= scale_sat(acc_z_nxt);
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Register read

  // Read mux; factory terms have no address at all
  always_comb begin
    rd_nxt = 16'h0000;
    if (hit(reg_req.addr, imu_pkg::OFS_YV_LO)) begin
      rd_nxt = dv_y_r[HI_LSB_M1:0];
    end else if (hit(reg_req.addr, imu_pkg::OFS_YV_HI)) begin
      rd_nxt = dv_y_r[31:imu_pkg::HI_LSB];
    end else if (hit(reg_req.addr, imu_pkg::OFS_ZV_LO)) begin
      rd_nxt = dv_z_r[HI_LSB_M1:0];
    end else if (hit(reg_req.addr, imu_pkg::OFS_ZV_HI)) begin
      rd_nxt = dv_z_r[31:imu_pkg::HI_LSB];
    end else if (hit(reg_req.addr, imu_pkg::OFS_XB_LO)) begin
      rd_nxt = xb_lo_r;
    end else if (hit(reg_req.addr, imu_pkg::OFS_XB_HI)) begin
      rd_nxt = xb_hi_r;
    end else if (hit(reg_req.addr, imu_pkg::OFS_YB_LO)) begin
      rd_nxt = yb_lo_r;
    end else if (hit(reg_req.addr, imu_pkg::OFS_YB_HI)) begin
      rd_nxt = yb_hi_r;
    end
  end

  // Data answers one cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rd_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_xlo_wr;
    reg_req.wr && hit(reg_req.addr, imu_pkg::OFS_XB_LO)
      |=> xb_lo_r == $past(reg_req.wdata);
  endproperty
  a_xlo_wr: assert property (p_xlo_wr) else $error("x low offset not stored");

  property p_xhi_wr;
    reg_req.wr && hit(reg_req.addr, imu_pkg::OFS_XB_HI)
      ##1 reg_req.rd && hit(reg_req.addr, imu_pkg::OFS_XB_HI)
      |=> reg_rdata == $past(reg_req.wdata, 2);
  endproperty
  a_xhi_wr: assert property (p_xhi_wr) else $error("x high offset readback wrong");

  property p_x_sum;
    tick |=> rate_valid && rate_x_out == $past(rate_x_raw) + $past({xb_hi_r, xb_lo_r});
  endproperty
  a_x_sum: assert property (p_x_sum) else $error("x rate correction wrong");

  property p_y_sum;
    tick |=> rate_y_out == $past(rate_y_raw) + $past({yb_hi_r, yb_lo_r});
  endproperty
  a_y_sum: assert property (p_y_sum) else $error("y rate correction wrong");

  property p_tick_gap;
    tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("sample strobe too close");

  property p_ro;
    reg_req.wr && !dec_done && hit(reg_req.addr, imu_pkg::OFS_YV_HI)
      |=> $stable(dv_y_r);
  endproperty
  a_ro: assert property (p_ro) else $error("velocity word took a write");

  property p_neg_clamp;
    dec_done && acc_z_nxt[ACC_W-1] && (acc_z_nxt < 40'hffffff0000)
      |=> dv_z_r == imu_pkg::DV_NEG_MAX;
  endproperty
  a_neg_clamp: assert property (p_neg_clamp) else $error("negative clamp missing");

  property p_rd_hi;
    reg_req.rd && hit(reg_req.addr, imu_pkg::OFS_YV_HI) && !dec_done
      |=> reg_rvalid && reg_rdata == dv_y_r[31:16];
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("y high word readback wrong");

  property p_rd_lo;
    reg_req.rd && hit(reg_req.addr, imu_pkg::OFS_ZV_LO) && !dec_done
      |=> reg_rdata == dv_z_r[15:0];
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("z low word readback wrong");

  property p_clamp;
    dec_done && !acc_y_nxt[ACC_W-1] && (acc_y_nxt > 40'h000000ffff)
      |=> dv_y_r == imu_pkg::DV_POS_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("positive clamp missing");

endmodule

`default_nettype wire

/* src/imu_pkg.sv */
// Shared constants and carrier types for the velocity-change
// and rate-offset register block.
// Assumes a 10 MHz ref_clk and 16-bit register words.
package imu_pkg;

  // Clock and sample rate
  localparam int CLK_HZ    = 10000000;
  localparam int SAMPLE_HZ = 2000;
  localparam int TICK_CYC  = CLK_HZ / SAMPLE_HZ;

  // Register byte offsets
  localparam logic [6:0] OFS_YV_LO = 7'h34;
  localparam logic [6:0] OFS_YV_HI = 7'h36;
  localparam logic [6:0] OFS_ZV_LO = 7'h38;
  localparam logic [6:0] OFS_ZV_HI = 7'h3a;
  localparam logic [6:0] OFS_XB_LO = 7'h40;
  localparam logic [6:0] OFS_XB_HI = 7'h42;
  localparam logic [6:0] OFS_YB_LO = 7'h44;
  localparam logic [6:0] OFS_YB_HI = 7'h46;

  // Reset values and field layout
  localparam logic [15:0] BIAS_RST = 16'h0000;
  localparam logic [31:0] DV_RST   = 32'h00000000;
  localparam int          HI_LSB   = 16;

  // Saturation codes of the 32-bit format
  localparam logic [31:0] DV_POS_MAX = 32'h7fffffff;
  localparam logic [31:0] DV_NEG_MAX = 32'h80000000;

  // Left shift that turns the trapezoid sum into
  // output codes; carries the 1/(2*fs) factor
  localparam int DV_SHIFT = 15;

  // One register access from the serial front end
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // One accelerometer sample pair
  typedef struct packed {
    logic [15:0] y;
    logic [15:0] z;
  } accel_t;

endpackage

/* test/sensor_src.sv */
// Sensor front-end model: feeds acceleration and raw rate samples.
// Assumes the bench sets the wanted values; all updates land on ref_clk.
`timescale 1ns/1ns
`default_nettype none

module sensor_src (
  input  wire logic            ref_clk,
  input  wire logic            rst_b,
  input  wire imu_pkg::accel_t accel_set,
  input  wire logic [31:0]     rx_set,
  input  wire logic [31:0]     ry_set,
  output var imu_pkg::accel_t  accel,
  output logic [31:0]          rate_x_raw,
  output logic [31:0]          rate_y_raw
);
  //////////////////////////////////////////////////////////////////////
  // Converter outputs change only on an edge, so the tick never sees a half update
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      accel      <= '0;
      rate_x_raw <= 32'h00000000;
      rate_y_raw <= 32'h00000000;
    end else begin
      accel      <= accel_set;
      rate_x_raw <= rx_set;
      rate_y_raw <= ry_set;
    end
  end
endmodule

`default_nettype wire

/* test/imu_dvel_gyro_bias_regs_test.sv */
// Bench for the velocity-change and rate-offset register block.
// Assumes the strobe register port of the design and a fast tick.
`timescale 1ns/1ns
`default_nettype none

module imu_dvel_gyro_bias_regs_test;
  localparam int TK = 20;
  logic              ref_clk;
  logic              rst_b;
  imu_pkg::reg_req_t reg_req;
  imu_pkg::accel_t   accel;
  imu_pkg::accel_t   accel_set;
  logic [15:0]       reg_rdata;
  logic [15:0]       decimation_setting;
  logic              reg_rvalid;
  logic              rate_valid;
  logic              dv_ready;
  logic [31:0]       rate_x_raw, rate_y_raw, rx_set, ry_set;
  logic [31:0]       rate_x_out, rate_y_out, flash_x_offset, flash_y_offset;
  logic [6:0]        ofs [4];
  logic [15:0]       wv [4];
  int                mismatches, check_count, n;

  //////////////////////////////////////////////////////////////////////
  // Design and sensor model
  imu_dvel_gyro_bias_regs #(.TICK_CYC(TK)) uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .accel(accel), .decimation_setting(decimation_setting),
    .rate_x_raw(rate_x_raw), .rate_y_raw(rate_y_raw), .rate_x_out(rate_x_out),
    .rate_y_out(rate_y_out), .rate_valid(rate_valid), .dv_ready(dv_ready),
    .flash_x_offset(flash_x_offset), .flash_y_offset(flash_y_offset));
  sensor_src src (.ref_clk(ref_clk), .rst_b(rst_b), .accel_set(accel_set), .rx_set(rx_set),
    .ry_set(ry_set), .accel(accel), .rate_x_raw(rate_x_raw), .rate_y_raw(rate_y_raw));

  //////////////////////////////////////////////////////////////////////
  // Clock at 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Comparison, bus cycles and pulse waits
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask
  // Read data is checked together with its one-cycle valid pulse
  task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
    check({reg_rvalid, reg_rdata}, {1'b1, exp});
  endtask
  // Bounded wait: sel 1 waits for dv_ready, 0 for rate_valid; n counts cycles
  task automatic wait_pulse(input bit sel);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while ((sel ? dv_ready : rate_valid) !== 1'b1 && n < 200);
    check(n < 200, 1);
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b = 1'b0;
    reg_req = '0;
    decimation_setting = 16'h0000;
    accel_set = '{y: 16'h0003, z: 16'hfffe};
    rx_set = 32'h00010000;
    ry_set = 32'h00000005;
    ofs = '{imu_pkg::OFS_XB_LO, imu_pkg::OFS_XB_HI, imu_pkg::OFS_YB_LO, imu_pkg::OFS_YB_HI};
    wv = '{16'hfffe, 16'hffff, 16'h1234, 16'h0000};
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (ofs[i]) rd_chk(ofs[i], 16'h0000);
    rd_chk(7'h50, 16'h0000);
    foreach (ofs[i]) wr(ofs[i], wv[i]);
    foreach (ofs[i]) rd_chk(ofs[i], wv[i]);
    rd_chk(7'h41, 16'hfffe);
    check(flash_x_offset, 32'hfffffffe);
    check(flash_y_offset, 32'h00001234);
    // Negative X offset must borrow across the word boundary
    wait_pulse(0);
    check(rate_x_out, 32'h0000fffe);
    check(rate_y_out, 32'h00001239);
    wait_pulse(0);
    check(n, TK);
    wr(7'h48, 16'h5555);
    rd_chk(7'h48, 16'h0000);
    // Write, then read the same word on the very next cycle
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: imu_pkg::OFS_XB_HI, wdata: 16'h8001};
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: imu_pkg::OFS_XB_HI, wdata: 16'h0000};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
    check({reg_rvalid, reg_rdata}, {1'b1, 16'h8001});
    // Steady samples: each result is twice the sample, shifted up 15
    wait_pulse(1);
    rd_chk(imu_pkg::OFS_YV_HI, 16'h0003);
    rd_chk(imu_pkg::OFS_YV_LO, 16'h0000);
    rd_chk(imu_pkg::OFS_ZV_HI, 16'hfffe);
    rd_chk(imu_pkg::OFS_ZV_LO, 16'h0000);
    wr(imu_pkg::OFS_YV_HI, 16'h5a5a);
    rd_chk(imu_pkg::OFS_YV_HI, 16'h0003);
    // A step in the sample leaves an odd trapezoid sum in the low word
    wait_pulse(1);
    accel_set <= '{y: 16'h0004, z: 16'hfffe};
    wait_pulse(1);
    rd_chk(imu_pkg::OFS_YV_HI, 16'h0003);
    rd_chk(imu_pkg::OFS_YV_LO, 16'h8000);
    // Full-scale samples, then a two-tick window that must clamp
    accel_set <= '{y: 16'h7fff, z: 16'h8000};
    repeat (2) wait_pulse(1);
    rd_chk(imu_pkg::OFS_YV_HI, 16'h7fff);
    rd_chk(imu_pkg::OFS_ZV_HI, 16'h8000);
    @(posedge ref_clk);
    decimation_setting <= 16'h0001;
    repeat (3) wait_pulse(1);
    rd_chk(imu_pkg::OFS_YV_HI, 16'h7fff);
    rd_chk(imu_pkg::OFS_YV_LO, 16'hffff);
    rd_chk(imu_pkg::OFS_ZV_HI, 16'h8000);
    rd_chk(imu_pkg::OFS_ZV_LO, 16'h0000);
    // A second reset in mid-run brings the offsets back to zero
    @(posedge ref_clk);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk(imu_pkg::OFS_XB_LO, 16'h0000);
    rd_chk(imu_pkg::OFS_XB_HI, 16'h0000);
    check(flash_y_offset, 32'h00000000);
    finish_test();
  end

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end
endmodule

`default_nettype wire
